// >>> src/lgs_pkg.sv
// Package: register map, field layout and bus types for the gate input select block
package lgs_pkg;
	localparam int NUM_GATES = 3;
	localparam int NUM_INPUTS = 4;
	localparam int NUM_SOURCES = 64;
	localparam int SRC_W = 6;
	localparam int TERM_W = 8;
	// Byte addresses of the registers
	localparam logic [7:0] OFF_GATE1_TERMS = 8'h00;
	localparam logic [7:0] OFF_GATE2_TERMS = 8'h04;
	localparam logic [7:0] OFF_GATE3_TERMS = 8'h08;
	localparam logic [7:0] OFF_GATE_POL = 8'h0C;
	localparam logic [7:0] OFF_SRC_SEL = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	// Field positions inside a term register: true term of input i at 2i+1, inverted at 2i
	localparam int TRUE_BIT_OFS = 1;
	localparam int INV_BIT_OFS = 0;
	// Source select register: 6-bit field per data input, one byte lane each
	localparam int SRC_FIELD_STRIDE = 8;
	// Values loaded at power-on (documented as undefined; zero chosen)
	localparam logic [TERM_W-1:0] TERMS_RESET = 8'h00;
	localparam logic [2:0] POL_RESET = 3'h0;
	localparam logic [SRC_W-1:0] SRC_RESET = 6'h00;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} lgs_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} lgs_apb_rsp_t;
endpackage

// >>> src/lgs_gate_select.sv
// Input gating matrix for gates 1..3 of a logic cell, with APB register access
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
module lgs_gate_select (
	input wire logic pclk,
	input wire logic presetn,
	input wire lgs_pkg::lgs_apb_req_t apb_req,
	output lgs_pkg::lgs_apb_rsp_t apb_rsp,
	input wire logic [lgs_pkg::NUM_SOURCES-1:0] cell_sources,
	output logic [lgs_pkg::NUM_GATES-1:0] gate_out
);
	import lgs_pkg::*;

	logic [TERM_W-1:0] terms_q [NUM_GATES];
	logic [TERM_W-1:0] terms_d [NUM_GATES];
	logic [NUM_GATES-1:0] pol_q, pol_d;
	logic [SRC_W-1:0] src_q [NUM_INPUTS];
	logic [SRC_W-1:0] src_d [NUM_INPUTS];
	logic [NUM_SOURCES-1:0] src_s1_q, src_s2_q;
	logic [NUM_INPUTS-1:0] data_in;
	logic [NUM_GATES-1:0] gate_raw, gate_d, gate_q;
	logic [31:0] rdata_d, rdata_q;
	logic wr_en, rd_en;

	// Term-gating OR of a gate: bit 2i+1 admits true input i, bit 2i inverted
	function automatic logic gate_eval(input logic [TERM_W-1:0] t,
			input logic [NUM_INPUTS-1:0] d);
		logic acc;
		acc = 1'b0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			acc = acc | (t[2*i+TRUE_BIT_OFS] & d[i]) | (t[2*i+INV_BIT_OFS] & ~d[i]);
		end
		return acc;
	endfunction

	// Writes decode in the access phase, reads in setup; pready is tied high, so no wait states
	assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd_en = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

	// Register write decode
	always_comb begin
		terms_d = terms_q;
		pol_d = pol_q;
		src_d = src_q;
		// Writes to the status word fall through every branch and change nothing
		if (wr_en) begin
			if (apb_req.paddr == OFF_GATE1_TERMS) begin
				terms_d[0] = apb_req.pwdata[TERM_W-1:0];
			end else if (apb_req.paddr == OFF_GATE2_TERMS) begin
				terms_d[1] = apb_req.pwdata[TERM_W-1:0];
			end else if (apb_req.paddr == OFF_GATE3_TERMS) begin
				terms_d[2] = apb_req.pwdata[TERM_W-1:0];
			end else if (apb_req.paddr == OFF_GATE_POL) begin
				pol_d = apb_req.pwdata[NUM_GATES-1:0];
			end else if (apb_req.paddr == OFF_SRC_SEL) begin
				for (int i = 0; i < NUM_INPUTS; i++) begin
					src_d[i] = apb_req.pwdata[i*SRC_FIELD_STRIDE +: SRC_W];
				end
			end
		end
	end

	// Read mux, captured in setup so prdata comes from a flop in the access phase
	always_comb begin
		rdata_d = rdata_q;
		if (rd_en) begin
			rdata_d = 32'h0000_0000;
			if (apb_req.paddr == OFF_GATE1_TERMS) begin
				rdata_d[TERM_W-1:0] = terms_q[0];
			end else if (apb_req.paddr == OFF_GATE2_TERMS) begin
				rdata_d[TERM_W-1:0] = terms_q[1];
			end else if (apb_req.paddr == OFF_GATE3_TERMS) begin
				rdata_d[TERM_W-1:0] = terms_q[2];
			end else if (apb_req.paddr == OFF_GATE_POL) begin
				rdata_d[NUM_GATES-1:0] = pol_q;
			end else if (apb_req.paddr == OFF_SRC_SEL) begin
				for (int i = 0; i < NUM_INPUTS; i++) begin
					rdata_d[i*SRC_FIELD_STRIDE +: SRC_W] = src_q[i];
				end
			end else if (apb_req.paddr == OFF_STATUS) begin
				rdata_d[NUM_GATES-1:0] = gate_q;
				rdata_d[8 +: NUM_INPUTS] = data_in;
			end
		end
	end

	// Unmapped addresses answer with an error; writes there change nothing
	always_comb begin
		apb_rsp.pready = 1'b1;
		apb_rsp.prdata = rdata_q;
		apb_rsp.pslverr = apb_req.psel & apb_req.penable &
			(apb_req.paddr != OFF_GATE1_TERMS) & (apb_req.paddr != OFF_GATE2_TERMS) &
			(apb_req.paddr != OFF_GATE3_TERMS) & (apb_req.paddr != OFF_GATE_POL) &
			(apb_req.paddr != OFF_SRC_SEL) & (apb_req.paddr != OFF_STATUS);
	end

	// Only presetn (power-on) clears config; no other reset reaches these flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int g = 0; g < NUM_GATES; g++) begin
				terms_q[g] <= TERMS_RESET;
			end
			for (int i = 0; i < NUM_INPUTS; i++) begin
				src_q[i] <= SRC_RESET;
			end
			pol_q <= POL_RESET;
			rdata_q <= 32'h0000_0000;
		end else begin
			terms_q <= terms_d;
			src_q <= src_d;
			pol_q <= pol_d;
			rdata_q <= rdata_d;
		end
	end

	// Sources may come from pins or other clocks, so synchronise all of them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_s1_q <= '0;
			src_s2_q <= '0;
		end else begin
			src_s1_q <= cell_sources;
			src_s2_q <= src_s1_q;
		end
	end

	// Data input selection from the synchronised sources
	always_comb begin
		for (int i = 0; i < NUM_INPUTS; i++) begin
			data_in[i] = src_s2_q[src_q[i]];
		end
	end

	// Gate matrix and polarity, one instance per gate
	for (genvar g = 0; g < NUM_GATES; g++) begin : g_gate
		assign gate_raw[g] = gate_eval(terms_q[g], data_in);
		assign gate_d[g] = gate_raw[g] ^ pol_q[g];
	end

	// Registered gate outputs keep the data outputs glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_q <= '0;
		end else begin
			gate_q <= gate_d;
		end
	end
	assign gate_out = gate_q;

	// Checker view of the matrix, laid out from the bit map rather than from gate_eval,
	// so a slip in the evaluation function cannot hide behind a matching assertion
	logic [TERM_W-1:0] chk_term_vec;
	logic [NUM_INPUTS-1:0] chk_src_bit;
	logic [NUM_GATES-1:0] chk_any_term;
	for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_chk_in
		assign chk_term_vec[2*i+1] = data_in[i];
		assign chk_term_vec[2*i] = ~data_in[i];
		assign chk_src_bit[i] = |(src_s2_q & ({{(NUM_SOURCES-1){1'b0}}, 1'b1} << src_q[i]));
	end
	for (genvar g = 0; g < NUM_GATES; g++) begin : g_chk_gate
		assign chk_any_term[g] = |(terms_q[g] & chk_term_vec);
	end

	// Gate outputs: one flop after the admitted terms and the polarity bit
	chk_gate1_terms: assert property (@(posedge pclk) disable iff (!presetn)
		gate_q[0] == ($past(chk_any_term[0]) ^ $past(pol_q[0])))
		else $error("gate 1 output mismatch");
	chk_gate2_terms: assert property (@(posedge pclk) disable iff (!presetn)
		gate_q[1] == ($past(chk_any_term[1]) ^ $past(pol_q[1])))
		else $error("gate 2 output mismatch");
	chk_gate3_terms: assert property (@(posedge pclk) disable iff (!presetn)
		gate_q[2] == ($past(chk_any_term[2]) ^ $past(pol_q[2])))
		else $error("gate 3 output mismatch");
	chk_empty_gate_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(terms_q[0] == 8'h00 && !pol_q[0]) |=> !gate_q[0])
		else $error("empty gate not zero");
	chk_pol_pass: assert property (@(posedge pclk) disable iff (!presetn)
		(!pol_q[0] && gate_raw[0]) |=> gate_q[0])
		else $error("polarity applied while clear");

	// Register side: writes land at the access edge and nowhere else
	chk_term_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && apb_req.paddr == OFF_GATE2_TERMS) |=>
		terms_q[1] == $past(apb_req.pwdata[7:0]))
		else $error("term write lost");
	chk_terms_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!wr_en |=> ($stable(terms_q[0]) && $stable(terms_q[1]) && $stable(terms_q[2])))
		else $error("term register changed without a write");
	chk_pol_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && apb_req.paddr == OFF_GATE_POL) |=> pol_q == $past(apb_req.pwdata[2:0]))
		else $error("polarity write lost");
	chk_src_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && apb_req.paddr == OFF_SRC_SEL) |=> src_q[3] == $past(apb_req.pwdata[29:24]))
		else $error("source select write lost");
	chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_req.psel && apb_req.penable && apb_req.paddr > OFF_STATUS) |-> apb_rsp.pslverr)
		else $error("unmapped access not refused");

	// Read side: data captured at setup and held until the next read setup
	chk_term_readback: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && apb_req.paddr == OFF_GATE1_TERMS) |=>
		apb_rsp.prdata == {24'h00_0000, $past(terms_q[0])})
		else $error("term readback wrong");
	chk_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!rd_en |=> $stable(apb_rsp.prdata))
		else $error("read data moved outside a read");
	chk_status_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && apb_req.paddr == OFF_STATUS) |=> apb_rsp.prdata[2:0] == $past(gate_q))
		else $error("status gate bits wrong");

	// Polarity and source selection
	chk_pol_invert: assert property (@(posedge pclk) disable iff (!presetn)
		(pol_q[1] && $stable(pol_q[1]) && gate_raw[1]) |=> !gate_q[1])
		else $error("polarity not applied");
	chk_src_select: assert property (@(posedge pclk) disable iff (!presetn)
		data_in == chk_src_bit)
		else $error("source select wrong");
endmodule

// >>> sim/lgs_gate_select_tb.sv
// Self-checking testbench for the gate input select block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, b); end end
module lgs_gate_select_tb;
	import lgs_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	lgs_apb_req_t apb_req = '0;
	lgs_apb_rsp_t apb_rsp;
	logic [NUM_SOURCES-1:0] cell_sources = '0;
	logic [NUM_GATES-1:0] gate_out;
	int err_count = 0;
	int tests_run = 0;
	integer seed = 26;
	logic [31:0] rd;
	logic err;
	logic [7:0] terms [NUM_GATES];
	logic [2:0] pol;
	logic [5:0] src [NUM_INPUTS];
	logic [3:0] din;
	logic [31:0] src_word;
	logic [2:0] gexp;

	lgs_gate_select u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .cell_sources(cell_sources), .gate_out(gate_out));

	// 40 MHz clock
	always #12.5 pclk = ~pclk;

	// Reference gate: OR of admitted terms, then the polarity flip
	function automatic logic gate_exp(input logic [7:0] t, input logic [3:0] d, input logic p);
		logic [7:0] f;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			f[2*i+TRUE_BIT_OFS] = d[i];
			f[2*i+INV_BIT_OFS] = ~d[i];
		end
		return (|(t & f)) ^ p;
	endfunction

	// One APB transfer; request left up so the next call can follow back to back
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin @(posedge pclk); n++; end while (apb_rsp.pready !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
	endtask

	// Release the bus and let the two-flop sync and gate flop settle
	task automatic settle();
		apb_req <= '0;
		repeat (5) @(posedge pclk);
	endtask

	task automatic summarize();
		$display("errors=%0d checks=%0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Watchdog sized well above the expected run length
	initial begin
		#(25 * 4000);
		err_count++;
		summarize();
	end

	// Main sequence: one-hot terms, all/none, then random
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFF_GATE1_TERMS, 32'h0);
		`CHK(rd[7:0], TERMS_RESET)
		for (int k = 0; k < 24; k++) begin
			for (int g = 0; g < NUM_GATES; g++)
				terms[g] = (k < 8) ? 8'h01 << k : (k == 8) ? 8'hFF : (k == 9) ? 8'h00 : 8'($random(seed));
			pol = (k < 10) ? 3'h0 : 3'($random(seed));
			for (int i = 0; i < NUM_INPUTS; i++) src[i] = 6'($random(seed));
			cell_sources <= {$random(seed), $random(seed)};
			for (int g = 0; g < NUM_GATES; g++) apb(1'b1, 8'(OFF_GATE1_TERMS + 4 * g), {24'h0, terms[g]});
			apb(1'b1, OFF_GATE_POL, {29'h0, pol});
			src_word = {2'b0, src[3], 2'b0, src[2], 2'b0, src[1], 2'b0, src[0]};
			apb(1'b1, OFF_SRC_SEL, src_word);
			settle();
			for (int i = 0; i < NUM_INPUTS; i++) din[i] = cell_sources[src[i]];
			for (int g = 0; g < NUM_GATES; g++) gexp[g] = gate_exp(terms[g], din, pol[g]);
			`CHK(gate_out, gexp)
			apb(1'b0, OFF_STATUS, 32'h0);
			`CHK(rd[11:8], din)
			`CHK(rd[2:0], gexp)
			apb(1'b0, OFF_GATE_POL, 32'h0);
			`CHK(rd[2:0], pol)
			apb(1'b0, OFF_SRC_SEL, 32'h0);
			`CHK(rd, src_word)
			for (int g = 0; g < NUM_GATES; g++) begin
				apb(1'b0, 8'(OFF_GATE1_TERMS + 4 * g), 32'h0);
				`CHK(rd[7:0], terms[g])
			end
			`CHK(err, 1'b0)
			settle();
		end
		// Unmapped address: error, write dropped, read as zero
		apb(1'b1, 8'h18, 32'hFFFF_FFFF);
		`CHK(err, 1'b1)
		apb(1'b0, 8'h18, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b0, OFF_GATE3_TERMS, 32'h0);
		`CHK(rd[7:0], terms[2])
		settle();
		summarize();
	end
endmodule
